// >>> imu_spi_register_access_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin bad_count++; \
    $display("BAD %s expected %h seen %h", nm, e, s); end end
// ==========================================================
// Bench
// ==========================================================
module imu_spi_register_access_test;
    localparam logic [63:0] SER = 64'h3736353433323130;
    logic                       core_clk = 1'b0;
    logic                       rst_n = 1'b0;
    logic                       sclk, cs_n, mosi, miso, miso_oe, data_ready, sample_ready;
    logic                       sample_valid = 1'b0;
    logic [1:0]                 fault = 2'b10;
    imuspi_pkg::imuspi_sample_s word = '0;
    logic                       sampling_mode;
    logic [7:0]                 rate_code, uart_control;
    logic [15:0]                rx;
    int                         bad_count = 0, n_checks = 0, cycles = 0, n;
    wire                        miso_w = miso_oe ? miso : 1'bz;

    always #4 core_clk = ~core_clk;

    imuspi_top #(.READY_CYCLES(600), .SERIAL_ASCII(SER)) i_imuspi_top (
        .core_clk(core_clk), .rst_n(rst_n), .spi_sclk(sclk), .spi_cs_n(cs_n),
        .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe), .data_ready(data_ready),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_word(word),
        .hardware_fault_field(fault), .sampling_mode(sampling_mode),
        .rate_code(rate_code), .uart_control(uart_control));
    imuspi_host i_imuspi_host (.core_clk(core_clk), .spi_sclk(sclk), .spi_cs_n(cs_n),
        .spi_mosi(mosi), .spi_miso(miso_w));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic wr(input logic [15:0] c);
        i_imuspi_host.xfer(c, rx);
    endtask
    // The answer to a read only arrives in the following frame.
    task automatic rd(input logic [6:0] a);
        i_imuspi_host.xfer({1'b0, a, 8'h00}, rx);
        i_imuspi_host.xfer(16'h0000, rx);
    endtask
    task automatic push(input logic [4:0] i);
        sample_valid = 1'b1;
        word = '{index: i, data: {8'ha5, 3'h0, i}};
        while (sample_ready !== 1'b1) @(negedge core_clk);
        @(negedge core_clk);
        sample_valid = 1'b0;
        @(negedge core_clk);
    endtask
    // Sample read order: flags, then 0x0e to 0x28, then pin state, counter last.
    function automatic logic [4:0] ix(input int k);
        ix = (k == 0) ? 5'h03 : (k < 15) ? 5'(k + 6) : 5'(k - 11);
    endfunction

    initial begin
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        wr(16'hfe01);
        rd(7'h0a);
        `CHK("not_ready", 1'b1, rx[10])
        for (n = 0; n < 20 && rx[10] !== 1'b0; n++) rd(7'h0a);
        `CHK("not_ready", 1'b0, rx[10])
        for (int i = 0; i < 4; i++) begin
            rd(7'h74 + 7'(2 * i));
            `CHK("serial", SER[16*i +: 16], rx)
        end
        rd(7'h7e);
        `CHK("page", 8'h01, rx[7:0])
        wr(16'h8504);
        wr(16'h8807);
        `CHK("rate", 8'h04, rate_code)
        `CHK("uart", 8'h07, uart_control)
        wr(16'h8800);
        `CHK("uart", 8'h00, uart_control)
        `CHK("rate", 8'h04, rate_code)
        wr(16'hfe00);
        rd(7'h7e);
        `CHK("page", 8'h00, rx[7:0])
        rd(7'h04);
        `CHK("fault", fault, rx[6:5])
        fault = 2'b00;
        rd(7'h04);
        `CHK("fault", 2'b00, rx[6:5])
        rd(7'h02);
        `CHK("mode", 8'h04, rx[15:8])
        rd(7'h7c);
        `CHK("unmapped", 16'h0000, rx)
        for (n = 0; n < 40 && sample_ready === 1'b1; n++) push(5'h03);
        `CHK("fill", 16, n)
        wr(16'h8301);
        `CHK("sampling", 1'b1, sampling_mode)
        rd(7'h02);
        `CHK("mode", 8'h00, rx[15:8])
        for (n = 0; n < 60 && sample_ready !== 1'b1; n++) @(negedge core_clk);
        `CHK("drained", 1'b1, sample_ready)
        for (int k = 0; k < 17; k++) push(ix(k));
        for (n = 0; n < 60 && data_ready !== 1'b1; n++) @(negedge core_clk);
        `CHK("data_ready", 1'b1, data_ready)
        i_imuspi_host.xfer({2'b00, ix(0), 9'h000}, rx);
        for (int k = 1; k <= 17; k++) begin
            i_imuspi_host.xfer(k < 17 ? {2'b00, ix(k), 9'h000} : 16'h0000, rx);
            `CHK("sample", {8'ha5, 3'h0, ix(k - 1)}, rx)
        end
        `CHK("data_ready", 1'b0, data_ready)
        wr(16'h8302);
        `CHK("sampling", 1'b0, sampling_mode)
        end_of_test();
    end
endmodule

// >>> imuspi_host.sv
`timescale 1ns/1ps
// ==========================================================
// Host link model
// ==========================================================
module imuspi_host (
    // Clock
    input  wire logic core_clk,
    // Link
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_mosi,
    input  wire logic spi_miso
);
    initial begin
        spi_sclk = 1'b1;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // Four core clocks per half period keep the link clock slow enough for the synchroniser.
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        @(negedge core_clk) spi_cs_n <= 1'b0;
        repeat (6) @(negedge core_clk);
        for (int b = 15; b >= 0; b--) begin
            spi_sclk <= 1'b0;
            spi_mosi <= tx[b];
            repeat (4) @(negedge core_clk);
            spi_sclk <= 1'b1;
            rx[b] = spi_miso;
            repeat (4) @(negedge core_clk);
        end
        spi_cs_n <= 1'b1;
        spi_mosi <= ~spi_mosi;
        repeat (6) @(negedge core_clk);
    endtask
endmodule

// >>> imuspi_pkg.sv
package imuspi_pkg;

    // ==========================================================
    // Link framing
    // ==========================================================
    localparam int unsigned WORD_BITS     = 16;
    localparam logic [3:0]  LAST_BIT      = 4'hf;
    localparam int unsigned ADDR_MSB      = 14;
    localparam int unsigned ADDR_LSB      = 8;
    localparam int unsigned WRITE_BIT     = 15;

    // ==========================================================
    // Register addresses (byte addresses on the link)
    // ==========================================================
    localparam logic [6:0]  ADDR_MODE_CTRL   = 7'h02;
    localparam logic [6:0]  ADDR_MODE_CMD    = 7'h03;
    localparam logic [6:0]  ADDR_DIAG_STATUS = 7'h04;
    localparam logic [6:0]  ADDR_RATE_WORD   = 7'h04;
    localparam logic [6:0]  ADDR_RATE_CODE   = 7'h05;
    localparam logic [6:0]  ADDR_SAMPLE_LO   = 7'h06;
    localparam logic [6:0]  ADDR_SAMPLE_HI   = 7'h28;
    localparam logic [6:0]  ADDR_UART_CTRL   = 7'h08;
    localparam logic [6:0]  ADDR_GLOBAL_CMD  = 7'h0a;
    localparam logic [6:0]  ADDR_COUNT       = 7'h0a;
    localparam logic [6:0]  ADDR_SERIAL1     = 7'h74;
    localparam logic [6:0]  ADDR_SERIAL2     = 7'h76;
    localparam logic [6:0]  ADDR_SERIAL3     = 7'h78;
    localparam logic [6:0]  ADDR_SERIAL4     = 7'h7a;
    localparam logic [6:0]  ADDR_PAGE_SELECT = 7'h7e;

    // ==========================================================
    // Field positions and values
    // ==========================================================
    localparam logic [7:0]  PAGE_0           = 8'h00;
    localparam logic [7:0]  PAGE_1           = 8'h01;
    localparam int unsigned NOT_READY_BIT    = 10;
    localparam int unsigned FAULT_LSB        = 5;
    localparam logic [7:0]  MODE_CONFIG_CODE = 8'h04;
    localparam logic [7:0]  MODE_SAMPLE_CODE = 8'h00;
    localparam logic [7:0]  CMD_START_SAMPLE = 8'h01;
    localparam logic [7:0]  CMD_STOP_SAMPLE  = 8'h02;
    localparam logic [4:0]  COUNT_INDEX      = 5'h05;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0]  RATE_CODE_RESET  = 8'h00;
    localparam logic [7:0]  UART_CTRL_RESET  = 8'h00;
    localparam logic [15:0] WORD_RESET       = 16'h0000;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int unsigned CLK_KHZ          = 125000;
    localparam int unsigned READY_TIME_MS    = 800;
    localparam int unsigned READY_CYCLES     = READY_TIME_MS * CLK_KHZ;

    // ==========================================================
    // Types
    // ==========================================================
    typedef struct packed {
        logic [4:0]  index;
        logic [15:0] data;
    } imuspi_sample_s;

    typedef enum logic [0:0] {
        IMUSPI_CONFIG   = 1'b0,
        IMUSPI_SAMPLING = 1'b1
    } imuspi_mode_e;

endpackage

// >>> imuspi_top.sv
`timescale 1ns/1ps

// ==============================================================
// Sample FIFO
// ==============================================================
module imuspi_fifo #(
    parameter int unsigned WIDTH = 21,
    parameter int unsigned DEPTH = 16
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned PW = $clog2(DEPTH);

    // Checked while the design is elaborated, so a bad depth never reaches the logic.
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin
        $error("FIFO depth must be a power of two of at least two.");
    end

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic [PW:0]      next_count;
    logic             push;
    logic             pop;

    assign push       = in_valid && in_ready;
    assign pop        = out_valid && out_ready;
    assign next_count = count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    assign out_data   = mem[rd_ptr];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            wr_ptr    <= wr_ptr + PW'(push);
            rd_ptr    <= rd_ptr + PW'(pop);
            count     <= next_count;
            in_ready  <= next_count != (PW+1)'(DEPTH);
            out_valid <= next_count != '0;
        end
    end
endmodule

// ==============================================================
// Host access logic
// ==============================================================
module imuspi_top #(
    parameter int unsigned READY_CYCLES = imuspi_pkg::READY_CYCLES,
    parameter int unsigned FIFO_DEPTH   = 16,
    parameter logic [63:0] SERIAL_ASCII = 64'h3736353433323130
) (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    // Serial link
    input  wire logic                   spi_sclk,
    input  wire logic                   spi_cs_n,
    input  wire logic                   spi_mosi,
    output logic                        spi_miso,
    output logic                        spi_miso_oe,
    output logic                        data_ready,
    // Sensor core sample stream
    input  wire logic                   sample_valid,
    output logic                        sample_ready,
    input  wire imuspi_pkg::imuspi_sample_s sample_word,
    // Core status and settings
    input  wire logic [1:0]             hardware_fault_field,
    output logic                        sampling_mode,
    output logic [7:0]                  rate_code,
    output logic [7:0]                  uart_control
);
    // The serial number default is arbitrary.
    if (READY_CYCLES < 2) begin
        $error("Start-up count must be at least two cycles.");
    end

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    logic [1:0] sclk_sync;
    logic [1:0] cs_sync;
    logic [1:0] mosi_sync;
    logic       sclk_prev;
    logic       cs_prev;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_sync <= 2'h3;
            cs_sync   <= 2'h3;
            mosi_sync <= 2'h0;
            sclk_prev <= 1'b1;
            cs_prev   <= 1'b1;
        end else begin
            sclk_sync <= {sclk_sync[0], spi_sclk};
            cs_sync   <= {cs_sync[0], spi_cs_n};
            mosi_sync <= {mosi_sync[0], spi_mosi};
            sclk_prev <= sclk_sync[1];
            cs_prev   <= cs_sync[1];
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic frame_start;
    logic in_frame;

    assign in_frame    = !cs_sync[1];
    assign frame_start = cs_prev && !cs_sync[1];
    assign sclk_rise   = in_frame && !sclk_prev && sclk_sync[1];
    assign sclk_fall   = in_frame && sclk_prev && !sclk_sync[1];

    // ==========================================================
    // Shift engine
    // ==========================================================
    logic [15:0] rx_shift;
    logic [3:0]  bit_count;
    logic [15:0] tx_shift;
    logic [15:0] response;
    logic        cmd_done;
    logic [15:0] cmd_word;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_shift  <= imuspi_pkg::WORD_RESET;
            bit_count <= 4'h0;
            cmd_done  <= 1'b0;
            cmd_word  <= imuspi_pkg::WORD_RESET;
        end else begin
            cmd_done <= 1'b0;
            if (frame_start) begin
                bit_count <= 4'h0;
            end else if (sclk_rise) begin
                rx_shift  <= {rx_shift[14:0], mosi_sync[1]};
                bit_count <= bit_count + 4'h1;
                if (bit_count == imuspi_pkg::LAST_BIT) begin
                    cmd_done <= 1'b1;
                    cmd_word <= {rx_shift[14:0], mosi_sync[1]};
                end
            end
        end
    end

    // Output changes on the falling edge so the host samples a settled bit on rising.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_shift    <= imuspi_pkg::WORD_RESET;
            spi_miso    <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else begin
            spi_miso_oe <= in_frame;
            if (frame_start) begin
                tx_shift <= response;
                spi_miso <= response[15];
            end else if (sclk_fall) begin
                spi_miso <= tx_shift[15];
                tx_shift <= {tx_shift[14:0], 1'b0};
            end
        end
    end

    // ==========================================================
    // Command decode
    // ==========================================================
    logic       cmd_write;
    logic [6:0] cmd_addr;
    logic [7:0] cmd_data;
    logic       write_done;
    logic       read_done;

    assign cmd_write  = cmd_word[imuspi_pkg::WRITE_BIT];
    assign cmd_addr   = cmd_word[imuspi_pkg::ADDR_MSB:imuspi_pkg::ADDR_LSB];
    assign cmd_data   = cmd_word[7:0];
    assign write_done = cmd_done && cmd_write;
    assign read_done  = cmd_done && !cmd_write;

    logic [7:0]  page_number;
    logic        page_one;
    logic        not_ready;
    logic [31:0] ready_count;
    logic [15:0] sample_bank [0:31];

    assign page_one = page_number == imuspi_pkg::PAGE_1;

    function automatic logic writes_to(input logic [6:0] a, input logic w1, input logic [6:0] t,
                                       input logic tw1);
        writes_to = (a == t) && (w1 == tw1);
    endfunction

    // Only one byte register is touched by one write command.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            page_number  <= imuspi_pkg::PAGE_0;
            rate_code    <= imuspi_pkg::RATE_CODE_RESET;
            uart_control <= imuspi_pkg::UART_CTRL_RESET;
        end else if (write_done) begin
            if (cmd_addr == imuspi_pkg::ADDR_PAGE_SELECT) begin
                page_number <= cmd_data;
            end else if (writes_to(cmd_addr, page_one, imuspi_pkg::ADDR_RATE_CODE, 1'b1)) begin
                rate_code <= cmd_data;
            end else if (writes_to(cmd_addr, page_one, imuspi_pkg::ADDR_UART_CTRL, 1'b1)) begin
                uart_control <= cmd_data;
            end
        end
    end

    // ==========================================================
    // Mode and start-up
    // ==========================================================
    imuspi_pkg::imuspi_mode_e mode;
    logic                     mode_cmd;

    assign mode_cmd = write_done
                   && writes_to(cmd_addr, page_one, imuspi_pkg::ADDR_MODE_CMD, 1'b0);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode          <= imuspi_pkg::IMUSPI_CONFIG;
            sampling_mode <= 1'b0;
        end else begin
            if (mode_cmd) begin
                case (cmd_data)
                    imuspi_pkg::CMD_START_SAMPLE: begin
                        mode          <= imuspi_pkg::IMUSPI_SAMPLING;
                        sampling_mode <= 1'b1;
                    end
                    imuspi_pkg::CMD_STOP_SAMPLE: begin
                        mode          <= imuspi_pkg::IMUSPI_CONFIG;
                        sampling_mode <= 1'b0;
                    end
                    default: begin
                        mode          <= mode;
                        sampling_mode <= sampling_mode;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_count <= 32'h0;
            not_ready   <= 1'b1;
        end else if (not_ready) begin
            if (ready_count == READY_CYCLES - 1) begin
                not_ready <= 1'b0;
            end else begin
                ready_count <= ready_count + 32'h1;
            end
        end
    end

    // ==========================================================
    // Sample path
    // ==========================================================
    imuspi_pkg::imuspi_sample_s fifo_word;
    logic                       fifo_valid;
    logic                       fifo_take;
    logic                       count_read;

    // Draining halts while a set waits for the host, so a set is never torn mid-read.
    assign fifo_take  = fifo_valid && sampling_mode && !data_ready;
    assign count_read = read_done && !page_one && cmd_addr == imuspi_pkg::ADDR_COUNT;

    imuspi_fifo #(
        .WIDTH ($bits(imuspi_pkg::imuspi_sample_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .in_data   (sample_word),
        .out_valid (fifo_valid),
        .out_ready (fifo_take),
        .out_data  (fifo_word)
    );

    always_ff @(posedge core_clk) begin
        if (fifo_take) begin
            sample_bank[fifo_word.index] <= fifo_word.data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_ready <= 1'b0;
        end else if (fifo_take && fifo_word.index == imuspi_pkg::COUNT_INDEX) begin
            data_ready <= 1'b1;
        end else if (count_read || !sampling_mode) begin
            data_ready <= 1'b0;
        end
    end

    // ==========================================================
    // Read response
    // ==========================================================
    function automatic logic [15:0] read_mux(input logic [6:0] a, input logic w1);
        logic [6:0] wa;
        wa       = {a[6:1], 1'b0};
        read_mux = imuspi_pkg::WORD_RESET;
        if (wa == imuspi_pkg::ADDR_PAGE_SELECT) begin
            read_mux = {8'h00, page_number};
        end else if (w1) begin
            case (wa)
                imuspi_pkg::ADDR_GLOBAL_CMD:  read_mux = 16'(not_ready)
                                                         << imuspi_pkg::NOT_READY_BIT;
                imuspi_pkg::ADDR_RATE_WORD:   read_mux = {rate_code, 8'h00};
                imuspi_pkg::ADDR_UART_CTRL:   read_mux = {8'h00, uart_control};
                imuspi_pkg::ADDR_SERIAL1:     read_mux = {SERIAL_ASCII[15:8], SERIAL_ASCII[7:0]};
                imuspi_pkg::ADDR_SERIAL2:     read_mux = SERIAL_ASCII[31:16];
                imuspi_pkg::ADDR_SERIAL3:     read_mux = SERIAL_ASCII[47:32];
                imuspi_pkg::ADDR_SERIAL4:     read_mux = SERIAL_ASCII[63:48];
                default:                      read_mux = imuspi_pkg::WORD_RESET;
            endcase
        end else if (wa == imuspi_pkg::ADDR_MODE_CTRL) begin
            read_mux = {(mode == imuspi_pkg::IMUSPI_CONFIG) ? imuspi_pkg::MODE_CONFIG_CODE
                                                             : imuspi_pkg::MODE_SAMPLE_CODE,
                        8'h00};
        end else if (wa == imuspi_pkg::ADDR_DIAG_STATUS) begin
            read_mux = 16'(hardware_fault_field) << imuspi_pkg::FAULT_LSB;
        end else if (wa >= imuspi_pkg::ADDR_SAMPLE_LO && wa <= imuspi_pkg::ADDR_SAMPLE_HI) begin
            read_mux = sample_bank[wa[5:1]];
        end
        return read_mux;
    endfunction

    // A write leaves a zero word behind, so the following transfer carries no data.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            response <= imuspi_pkg::WORD_RESET;
        end else if (read_done) begin
            response <= read_mux(cmd_addr, page_one);
        end else if (write_done) begin
            response <= imuspi_pkg::WORD_RESET;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    page_write_a: assert property (
        write_done && cmd_addr == imuspi_pkg::ADDR_PAGE_SELECT
        |=> page_number == $past(cmd_data)
    ) else $error("Page select did not take the written byte.");

    serial_read_a: assert property (
        read_done && page_one && cmd_addr == imuspi_pkg::ADDR_SERIAL1
        |=> response == SERIAL_ASCII[15:0]
    ) else $error("Serial word one is wrong.");

    ready_time_a: assert property (
        $fell(not_ready) |-> $past(ready_count) == READY_CYCLES - 1
    ) else $error("Not-ready flag cleared at the wrong time.");

    fault_read_a: assert property (
        read_done && !page_one && cmd_addr == imuspi_pkg::ADDR_DIAG_STATUS
        |=> response[6:5] == $past(hardware_fault_field) && response[15:7] == 9'h000
    ) else $error("Fault field read back wrong.");

    frame_load_a: assert property (
        frame_start |=> tx_shift == $past(response) && spi_miso == $past(response[15])
    ) else $error("Response not loaded at frame start.");

    msb_first_a: assert property (
        sclk_fall && !frame_start |=> spi_miso == $past(tx_shift[15])
    ) else $error("Serial output not most significant bit first.");

    write_silent_a: assert property (
        write_done |=> response == imuspi_pkg::WORD_RESET
    ) else $error("Write left a response behind.");

    single_byte_a: assert property (
        write_done && cmd_addr == imuspi_pkg::ADDR_PAGE_SELECT
        |=> $stable(rate_code) && $stable(uart_control)
    ) else $error("Write touched more than one byte.");

    mode_read_a: assert property (
        read_done && !page_one && cmd_addr == imuspi_pkg::ADDR_MODE_CTRL && !sampling_mode
        |=> response == {imuspi_pkg::MODE_CONFIG_CODE, 8'h00}
    ) else $error("Mode word wrong in Configuration mode.");

    mode_enter_a: assert property (
        mode_cmd && cmd_data == imuspi_pkg::CMD_START_SAMPLE |=> sampling_mode
    ) else $error("Sampling mode not entered.");

    mode_exit_a: assert property (
        mode_cmd && cmd_data == imuspi_pkg::CMD_STOP_SAMPLE |=> !sampling_mode ##1 !data_ready
    ) else $error("Configuration mode not restored.");

    ready_cause_a: assert property (
        $rose(data_ready) |-> $past(sampling_mode) && $past(fifo_take)
    ) else $error("Data ready rose without a finished set.");

    count_clear_a: assert property (
        count_read && !(fifo_take && fifo_word.index == imuspi_pkg::COUNT_INDEX) |=> !data_ready
    ) else $error("Counter read did not release data ready.");
endmodule
